// ==== rtl/dcs_word_ctrl.sv ====
// Drive command word decoder and feedback word builder
`include "dcs_consts.svh"

module dcs_word_ctrl #(
    parameter int ACK_HOLD_CYC = `DCS_ACK_HOLD_CYC,
    parameter bit NEW_REVISION = 1'b1,
    parameter int FAULT_W = 16
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic telegram_strobe,
    input wire dcs_pkg::dcs_word_t drive_command_word,
    input wire dcs_pkg::dcs_word_t speed_setpoint_word,
    input wire dcs_pkg::dcs_word_t target_torque_word,
    input wire logic net_mode,
    input wire logic master_run,
    input wire logic speed_ctrl,
    input wire logic pos_ctrl,
    input wire logic auto_restart,
    input wire logic net_speed_source,
    input wire logic fault_event,
    input wire logic fault_severe,
    input wire logic [FAULT_W-1:0] fault_code,
    input wire logic warning_active,
    input wire logic drive_reset,
    input wire logic ext_shutoff,
    input wire logic decel_done,
    output dcs_pkg::dcs_word_t drive_feedback_word,
    output dcs_pkg::dcs_word_t speed_command,
    output dcs_pkg::dcs_word_t torque_command,
    output logic start_cmd,
    output logic reverse_cmd,
    output logic shutoff_cmd,
    output logic quick_stop_cmd,
    output logic ramp_hold,
    output logic freq_update_hold,
    output logic pos_start_cmd,
    output logic fault_clear,
    output logic [FAULT_W-1:0] fault_number_record
);
    import dcs_pkg::*;

    // =================================================================
    // Command word capture
    dcs_word_t cmd_reg;
    logic ctrl_en;
    logic on_b, coast_rel, quick_rel, op_en, ramp_run, setp_en, ack_b;
    logic trq_en, dir_inv, pos_b;
    dcs_state_t state_reg, state_next;
    logic fault_reg, severe_reg;
    logic ack_prev_reg;
    logic [31:0] ack_cnt_reg;
    logic ack_armed_reg;
    logic ack_done;
    logic force_inhibit;

    // Unused bits are masked so a careless master cannot steer anything
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cmd_reg <= `DCS_CMD_RESET;
        end else if (telegram_strobe) begin
            cmd_reg <= drive_command_word & ~`DCS_CMD_UNUSED_MASK;
        end
    end

    // Whole word is ignored while bit 10 is low; bits read as idle
    assign ctrl_en = cmd_reg[`DCS_CMD_CTRL_EN] && net_mode;
    assign on_b = ctrl_en && cmd_reg[`DCS_CMD_ON];
    assign coast_rel = !ctrl_en || cmd_reg[`DCS_CMD_COAST_REL];
    assign quick_rel = !ctrl_en || cmd_reg[`DCS_CMD_QUICK_REL];
    assign op_en = ctrl_en && cmd_reg[`DCS_CMD_OP_EN];
    assign ramp_run = !ctrl_en || cmd_reg[`DCS_CMD_RAMP_RUN];
    assign setp_en = ctrl_en && cmd_reg[`DCS_CMD_SETP_EN];
    assign ack_b = ctrl_en && cmd_reg[`DCS_CMD_FAULT_ACK];
    assign trq_en = ctrl_en && cmd_reg[`DCS_CMD_TORQUE_EN];
    assign dir_inv = ctrl_en && cmd_reg[`DCS_CMD_DIR_INV];
    assign pos_b = ctrl_en && cmd_reg[`DCS_CMD_POS_START];

    // =================================================================
    // Fault acknowledge: rising edge arms, 20 ms of high level fires
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_prev_reg <= 1'b0;
            ack_armed_reg <= 1'b0;
            ack_cnt_reg <= 32'h0000_0000;
        end else begin
            ack_prev_reg <= ack_b;
            if (!ack_b) begin
                ack_armed_reg <= 1'b0;
                ack_cnt_reg <= 32'h0000_0000;
            end else if (!ack_prev_reg) begin
                ack_armed_reg <= 1'b1;
                ack_cnt_reg <= 32'h0000_0001;
            end else if (ack_armed_reg && ack_cnt_reg < ACK_HOLD_CYC[31:0]) begin
                ack_cnt_reg <= ack_cnt_reg + 32'h0000_0001;
            end else if (ack_done) begin
                ack_armed_reg <= 1'b0; // One clear per edge
            end
        end
    end
    // The bit must still stand when the clear fires, not only while counting
    assign ack_done = ack_armed_reg && ack_b && ack_cnt_reg >= ACK_HOLD_CYC[31:0];

    // =================================================================
    // Fault latch; a new fault wins over an acknowledge in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fault_reg <= 1'b0;
            severe_reg <= 1'b0;
            fault_number_record <= '0;
        end else if (fault_event) begin
            fault_reg <= 1'b1;
            severe_reg <= severe_reg | fault_severe;
            fault_number_record <= fault_code;
        end else if (drive_reset) begin
            fault_reg <= 1'b0;
            severe_reg <= 1'b0;
            fault_number_record <= '0;
        end else if (ack_done && !severe_reg) begin
            fault_reg <= 1'b0;
            fault_number_record <= '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fault_clear <= 1'b0;
        end else begin
            fault_clear <= ack_done && !severe_reg && !fault_event;
        end
    end

    // =================================================================
    // Drive state sequence
    assign force_inhibit = fault_reg || !net_mode ||
                           (!master_run && state_reg == DCS_ST_OPER);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DCS_ST_INHIBIT: begin
                if (coast_rel && quick_rel && !on_b) state_next = DCS_ST_READY;
            end
            DCS_ST_READY: begin
                if (!coast_rel || !quick_rel) state_next = DCS_ST_INHIBIT;
                else if (on_b) state_next = DCS_ST_STANDBY;
            end
            DCS_ST_STANDBY: begin
                if (!coast_rel || !quick_rel) state_next = DCS_ST_INHIBIT;
                else if (!on_b) state_next = DCS_ST_READY;
                else if (op_en && !ext_shutoff) state_next = DCS_ST_OPER;
            end
            DCS_ST_OPER: begin
                if (!coast_rel) state_next = DCS_ST_INHIBIT;
                else if (!quick_rel || !on_b) state_next = DCS_ST_STOPPING;
                else if (!op_en) state_next = DCS_ST_STANDBY;
            end
            DCS_ST_STOPPING: begin
                if (!coast_rel) state_next = DCS_ST_INHIBIT;
                else if (decel_done) state_next = quick_rel ? DCS_ST_READY : DCS_ST_INHIBIT;
            end
            default: state_next = DCS_ST_INHIBIT;
        endcase
        if (force_inhibit) state_next = DCS_ST_INHIBIT;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= DCS_ST_INHIBIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // =================================================================
    // Drive commands
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            start_cmd <= 1'b0;
            shutoff_cmd <= 1'b1;
            quick_stop_cmd <= 1'b0;
            ramp_hold <= 1'b0;
            freq_update_hold <= 1'b0;
            pos_start_cmd <= 1'b0;
        end else begin
            start_cmd <= state_reg == DCS_ST_OPER;
            shutoff_cmd <= !coast_rel || state_reg == DCS_ST_INHIBIT ||
                           state_reg == DCS_ST_READY;
            quick_stop_cmd <= !quick_rel;
            // Freeze is meaningless without a start or mid restart
            if (speed_ctrl && state_reg == DCS_ST_OPER && !auto_restart && !ramp_run) begin
                ramp_hold <= NEW_REVISION || net_speed_source;
                freq_update_hold <= !NEW_REVISION && net_speed_source;
            end else begin
                ramp_hold <= 1'b0;
                freq_update_hold <= 1'b0;
            end
            pos_start_cmd <= pos_b && pos_ctrl && state_reg == DCS_ST_OPER;
        end
    end

    // Setpoint and torque paths; direction follows sign, optionally inverted
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            speed_command <= 16'h0000;
            torque_command <= 16'h0000;
            reverse_cmd <= 1'b0;
        end else begin
            speed_command <= setp_en ? speed_setpoint_word : 16'h0000;
            torque_command <= trq_en ? target_torque_word : 16'h0000;
            reverse_cmd <= setp_en && (speed_setpoint_word[15] ^ dir_inv);
        end
    end

    // =================================================================
    // Feedback word, refreshed with each telegram exchange
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drive_feedback_word <= `DCS_FB_RESET;
        end else if (telegram_strobe) begin
            drive_feedback_word <= 16'h0000;
            drive_feedback_word[`DCS_FB_READY_SW] <= state_reg == DCS_ST_READY;
            drive_feedback_word[`DCS_FB_STANDBY] <= state_reg == DCS_ST_STANDBY;
            drive_feedback_word[`DCS_FB_OP_EN] <= state_reg == DCS_ST_OPER;
            drive_feedback_word[`DCS_FB_FAULT] <= fault_reg;
            drive_feedback_word[`DCS_FB_COAST_REL] <= coast_rel;
            drive_feedback_word[`DCS_FB_QUICK_REL] <= quick_rel;
            drive_feedback_word[`DCS_FB_INHIBIT] <= state_reg == DCS_ST_INHIBIT;
            drive_feedback_word[`DCS_FB_WARN] <= warning_active;
            drive_feedback_word[`DCS_FB_CTRL_REQ] <= ctrl_en;
        end
    end

    // =================================================================
    // Checks
    // Independent count of how long the acknowledge bit has stood high
    logic [31:0] ack_run_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_run_reg <= 32'h0000_0000;
        end else if (!ack_b) begin
            ack_run_reg <= 32'h0000_0000;
        end else if (ack_run_reg != 32'hffff_ffff) begin
            ack_run_reg <= ack_run_reg + 32'h0000_0001;
        end
    end

    property p_unused_zero;
        @(posedge clk_sys) disable iff (!arst_n)
        (drive_feedback_word & 16'hfd00) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused feedback bit set");

    property p_refresh;
        @(posedge clk_sys) disable iff (!arst_n)
        telegram_strobe |=> drive_feedback_word[`DCS_FB_FAULT] == $past(fault_reg);
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("feedback not refreshed");

    property p_torque_zero;
        @(posedge clk_sys) disable iff (!arst_n)
        !trq_en |=> torque_command == 16'h0000;
    endproperty
    a_torque_zero: assert property (p_torque_zero)
        else $error("torque not forced zero");

    property p_setp_zero;
        @(posedge clk_sys) disable iff (!arst_n)
        !setp_en |=> speed_command == 16'h0000 && !reverse_cmd;
    endproperty
    a_setp_zero: assert property (p_setp_zero)
        else $error("setpoint not forced zero");

    property p_fault_set;
        @(posedge clk_sys) disable iff (!arst_n)
        fault_event |=> fault_reg ##1 state_reg == DCS_ST_INHIBIT;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault did not inhibit");

    property p_severe_kept;
        @(posedge clk_sys) disable iff (!arst_n)
        severe_reg && !drive_reset && !fault_event |=> $stable(fault_reg) || fault_reg;
    endproperty
    a_severe_kept: assert property (p_severe_kept)
        else $error("severe fault cleared");

    property p_ack_time;
        @(posedge clk_sys) disable iff (!arst_n)
        ack_done |-> ack_run_reg >= ACK_HOLD_CYC[31:0];
    endproperty
    a_ack_time: assert property (p_ack_time)
        else $error("acknowledge too early");

    property p_pos_start;
        @(posedge clk_sys) disable iff (!arst_n)
        pos_start_cmd |-> $past(pos_ctrl) && $past(state_reg == DCS_ST_OPER);
    endproperty
    a_pos_start: assert property (p_pos_start)
        else $error("positioning start out of state");

    property p_quick;
        @(posedge clk_sys) disable iff (!arst_n)
        (ctrl_en && !cmd_reg[`DCS_CMD_QUICK_REL]) |=> quick_stop_cmd;
    endproperty
    a_quick: assert property (p_quick)
        else $error("quick stop missed");

    property p_ignore;
        @(posedge clk_sys) disable iff (!arst_n)
        !ctrl_en ##1 !ctrl_en |=> !start_cmd;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("word acted on while disabled");

    property p_fb_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        !telegram_strobe |=> $stable(drive_feedback_word);
    endproperty
    a_fb_hold: assert property (p_fb_hold)
        else $error("feedback changed between telegrams");

    property p_record;
        @(posedge clk_sys) disable iff (!arst_n)
        fault_event |=> fault_number_record == $past(fault_code);
    endproperty
    a_record: assert property (p_record)
        else $error("fault code not recorded");

    property p_clear_once;
        @(posedge clk_sys) disable iff (!arst_n)
        fault_clear |=> !fault_clear;
    endproperty
    a_clear_once: assert property (p_clear_once)
        else $error("fault cleared twice for one edge");
endmodule // dcs_word_ctrl

// ==== rtl/dcs_consts.svh ====
// Constants for the drive command and feedback word block
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
// =====================================================================
// Command word bit positions
`define DCS_CMD_ON 0
`define DCS_CMD_COAST_REL 1
`define DCS_CMD_QUICK_REL 2
`define DCS_CMD_OP_EN 3
`define DCS_CMD_RAMP_RUN 5
`define DCS_CMD_SETP_EN 6
`define DCS_CMD_FAULT_ACK 7
`define DCS_CMD_CTRL_EN 10
`define DCS_CMD_TORQUE_EN 11
`define DCS_CMD_DIR_INV 12
`define DCS_CMD_POS_START 13
// Bits the master must keep at zero
`define DCS_CMD_UNUSED_MASK 16'hc310
// =====================================================================
// Feedback word bit positions
`define DCS_FB_READY_SW 0
`define DCS_FB_STANDBY 1
`define DCS_FB_OP_EN 2
`define DCS_FB_FAULT 3
`define DCS_FB_COAST_REL 4
`define DCS_FB_QUICK_REL 5
`define DCS_FB_INHIBIT 6
`define DCS_FB_WARN 7
`define DCS_FB_CTRL_REQ 9
// =====================================================================
// Reset values and timing
`define DCS_CMD_RESET 16'h0000
`define DCS_FB_RESET 16'h0000
`define DCS_CLK_MHZ 125
`define DCS_ACK_HOLD_MS 20
`define DCS_ACK_HOLD_CYC (`DCS_ACK_HOLD_MS * 1000 * `DCS_CLK_MHZ)
`endif

// ==== rtl/dcs_pkg.sv ====
// Types shared by the drive command and feedback word block
package dcs_pkg;
    // =================================================================
    // Drive states, one-hot
    typedef enum logic [4:0] {
        DCS_ST_INHIBIT = 5'b00001,
        DCS_ST_READY = 5'b00010,
        DCS_ST_STANDBY = 5'b00100,
        DCS_ST_OPER = 5'b01000,
        DCS_ST_STOPPING = 5'b10000
    } dcs_state_t;
    typedef logic [15:0] dcs_word_t;
endpackage

// ==== bench/dcs_master_model.sv ====
// Network master model that sends cyclic command telegrams to the drive
`include "dcs_consts.svh"
module dcs_master_model (
    input wire logic clk_sys,
    output logic telegram_strobe = 1'b0,
    output dcs_pkg::dcs_word_t drive_command_word = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcs_pkg::*;
    dcs_word_t cmd_word = 16'h0000;
    logic [1:0] phase = 2'h0;
    // ==================================================================
    // Telegram every fourth cycle; between telegrams the used bits are inverted
    // so that a design sampling off the strobe sees garbage, not stale data
    always @(posedge clk_sys) begin
        phase <= phase + 2'h1;
        telegram_strobe <= (phase == 2'h3);
        if (phase == 2'h3) begin
            drive_command_word <= cmd_word & ~`DCS_CMD_UNUSED_MASK;
        end else begin
            drive_command_word <= ~cmd_word & ~`DCS_CMD_UNUSED_MASK;
        end
    end
endmodule // dcs_master_model

// ==== bench/drive_control_status_words_test.sv ====
// Self-checking testbench for the drive command and feedback word block
module drive_control_status_words_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dcs_pkg::*;
    typedef struct packed {dcs_word_t exp; dcs_word_t mask;} dcs_note_t;
    logic clk_sys = 1'b0, arst_n = 1'b0, telegram_strobe, strobe_d = 1'b0;
    logic net_mode = 1'b1, master_run = 1'b1, speed_ctrl = 1'b1, pos_ctrl = 1'b0;
    logic auto_restart = 1'b0, net_speed_source = 1'b1, fault_event = 1'b0;
    logic fault_severe = 1'b0, warning_active = 1'b0, drive_reset = 1'b0;
    logic ext_shutoff = 1'b0, decel_done = 1'b0;
    dcs_word_t drive_command_word, speed_setpoint_word = 16'h0000;
    dcs_word_t target_torque_word = 16'h0000, fault_code = 16'h0000;
    dcs_word_t drive_feedback_word, speed_command, torque_command, fault_number_record;
    logic start_cmd, reverse_cmd, shutoff_cmd, quick_stop_cmd, ramp_hold;
    logic freq_update_hold, pos_start_cmd, fault_clear;
    logic old_ramp_hold, old_freq_hold, frz;
    logic [1:0] r;
    dcs_note_t notes[$];
    dcs_note_t note;
    dcs_word_t w, s, t, c;
    int n_fail = 0, n_checks = 0, n_clr = 0;
    // ==================================================================
    // Clock and design
    always #4ns clk_sys = ~clk_sys;
    dcs_master_model m (.clk_sys(clk_sys), .telegram_strobe(telegram_strobe),
        .drive_command_word(drive_command_word));
    dcs_word_ctrl #(.ACK_HOLD_CYC(20), .NEW_REVISION(1'b1), .FAULT_W(16)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .telegram_strobe(telegram_strobe),
        .drive_command_word(drive_command_word), .speed_setpoint_word(speed_setpoint_word),
        .target_torque_word(target_torque_word), .net_mode(net_mode),
        .master_run(master_run), .speed_ctrl(speed_ctrl), .pos_ctrl(pos_ctrl),
        .auto_restart(auto_restart), .net_speed_source(net_speed_source),
        .fault_event(fault_event), .fault_severe(fault_severe), .fault_code(fault_code),
        .warning_active(warning_active), .drive_reset(drive_reset),
        .ext_shutoff(ext_shutoff), .decel_done(decel_done),
        .drive_feedback_word(drive_feedback_word), .speed_command(speed_command),
        .torque_command(torque_command), .start_cmd(start_cmd), .reverse_cmd(reverse_cmd),
        .shutoff_cmd(shutoff_cmd), .quick_stop_cmd(quick_stop_cmd), .ramp_hold(ramp_hold),
        .freq_update_hold(freq_update_hold), .pos_start_cmd(pos_start_cmd),
        .fault_clear(fault_clear), .fault_number_record(fault_number_record));
    // Older-revision freeze, fed the same inputs
    dcs_word_ctrl #(.ACK_HOLD_CYC(20), .NEW_REVISION(1'b0), .FAULT_W(16)) dut_old (
        .clk_sys(clk_sys), .arst_n(arst_n), .telegram_strobe(telegram_strobe),
        .drive_command_word(drive_command_word), .speed_setpoint_word(speed_setpoint_word),
        .target_torque_word(target_torque_word), .net_mode(net_mode),
        .master_run(master_run), .speed_ctrl(speed_ctrl), .pos_ctrl(pos_ctrl),
        .auto_restart(auto_restart), .net_speed_source(net_speed_source),
        .fault_event(fault_event), .fault_severe(fault_severe), .fault_code(fault_code),
        .warning_active(warning_active), .drive_reset(drive_reset),
        .ext_shutoff(ext_shutoff), .decel_done(decel_done),
        .drive_feedback_word(), .speed_command(), .torque_command(), .start_cmd(),
        .reverse_cmd(), .shutoff_cmd(), .quick_stop_cmd(), .ramp_hold(old_ramp_hold),
        .freq_update_hold(old_freq_hold), .pos_start_cmd(), .fault_clear(),
        .fault_number_record());
    // ==================================================================
    // Shared tasks
    task automatic check_out(input string name, input dcs_word_t exp, input dcs_word_t got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tg(input int n);
        repeat (n) @(posedge clk_sys iff telegram_strobe);
    endtask
    // Word reaches the design at the next telegram; four telegrams let state settle
    task automatic send(input dcs_word_t word);
        @(posedge clk_sys);
        m.cmd_word <= word;
        tg(4);
    endtask
    task automatic expect_fb(input dcs_word_t e, input dcs_word_t k);
        tg(1);
        notes.push_back('{e, k});
        tg(1);
    endtask
    // ==================================================================
    // Feedback watcher: the word built at a telegram edge is seen one cycle on
    always @(posedge clk_sys) begin
        strobe_d <= telegram_strobe;
        if (fault_clear === 1'b1) n_clr++;
        if (strobe_d && notes.size() > 0) begin
            note = notes.pop_front();
            check_out("feedback", note.exp, drive_feedback_word & note.mask);
        end
    end
    // Watchdog sized well above the expected run of well under a thousand cycles
    initial begin
        #(8ns * 20000);
        n_fail++;
        print_verdict();
    end
    // ==================================================================
    // Main sequence
    initial begin
        void'($urandom(52));
        // Reset values settle at the first edge; look at them on the second
        @(posedge clk_sys);
        @(posedge clk_sys);
        check_out("shutoff", 16'h0001, 16'(shutoff_cmd));
        check_out("feedback", 16'h0000, drive_feedback_word);
        arst_n <= 1'b1;
        $display("Test reset done");
        send(16'h040e);
        expect_fb(16'h0001, 16'hfdc7);
        send(16'h040f);
        expect_fb(16'h0234, 16'hfff7);
        check_out("start", 16'h0001, 16'(start_cmd));
        check_out("shutoff", 16'h0000, 16'(shutoff_cmd));
        warning_active <= 1'b1;
        expect_fb(16'h02b4, 16'hfff7);
        warning_active <= 1'b0;
        $display("Test enable walk done");
        // Every mix of ramp, setpoint, torque and direction bits
        for (int i = 0; i < 16; i++) begin
            w = 16'h040f | {3'h0, i[3], i[2], 4'h0, i[1], i[0], 5'h0};
            s = 16'($urandom_range(16'hfffe, 1));
            t = 16'($urandom);
            r = 2'($urandom);
            frz = !i[0] && !r[1];
            speed_setpoint_word <= s;
            target_torque_word <= t;
            net_speed_source <= r[0];
            auto_restart <= r[1];
            send(w);
            check_out("speed", i[1] ? s : 16'h0000, speed_command);
            check_out("torque", i[2] ? t : 16'h0000, torque_command);
            if (i[1]) check_out("reverse", 16'(s[15] ^ i[3]), 16'(reverse_cmd));
            check_out("ramp", 16'(frz), 16'(ramp_hold));
            check_out("freq", 16'h0000, 16'(freq_update_hold));
            check_out("old ramp", 16'(frz && r[0]), 16'(old_ramp_hold));
            check_out("old freq", 16'(frz && r[0]), 16'(old_freq_hold));
        end
        $display("Test setpoint mix done");
        net_speed_source <= 1'b1;
        auto_restart <= 1'b0;
        speed_ctrl <= 1'b0;
        pos_ctrl <= 1'b1;
        send(16'h240f);
        check_out("pos", 16'h0001, 16'(pos_start_cmd));
        send(16'h040f);
        check_out("pos", 16'h0000, 16'(pos_start_cmd));
        speed_ctrl <= 1'b1;
        pos_ctrl <= 1'b0;
        // Master stop while operating, then a word with control disabled
        master_run <= 1'b0;
        tg(2);
        expect_fb(16'h0040, 16'h0047);
        master_run <= 1'b1;
        send(16'h040e);
        send(16'h040f);
        check_out("start", 16'h0001, 16'(start_cmd));
        send(16'h000f);
        check_out("start", 16'h0000, 16'(start_cmd));
        send(16'h040b);
        check_out("quick", 16'h0001, 16'(quick_stop_cmd));
        expect_fb(16'h0000, 16'h0020);
        send(16'h000b);
        check_out("quick", 16'h0000, 16'(quick_stop_cmd));
        decel_done <= 1'b1;
        net_mode <= 1'b0;
        tg(2);
        expect_fb(16'h0040, 16'h0247);
        net_mode <= 1'b1;
        decel_done <= 1'b0;
        $display("Test stop and gating done");
        // Plain fault acknowledged, then severe fault that only a reset clears
        for (int k = 0; k < 2; k++) begin
            c = 16'($urandom) | 16'h0001;
            @(posedge clk_sys);
            fault_event <= 1'b1;
            fault_severe <= k[0];
            fault_code <= c;
            @(posedge clk_sys);
            fault_event <= 1'b0;
            expect_fb(16'h0048, 16'hfdcf);
            check_out("record", c, fault_number_record);
            send(16'h0486);
            check_out("early", c, fault_number_record);
            tg(4);
            check_out("record", k[0] ? c : 16'h0000, fault_number_record);
            check_out("clears", 16'h0001, 16'(n_clr));
            send(16'h0406);
        end
        drive_reset <= 1'b1;
        @(posedge clk_sys);
        drive_reset <= 1'b0;
        tg(1);
        check_out("record", 16'h0000, fault_number_record);
        $display("Test faults done");
        print_verdict();
    end
endmodule // drive_control_status_words_test
